// ### shared/csc_cfg.svh
// Offsets, field positions, reset values and timing counts of the
// communication setup block. Included by bare name; definitions only.
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH

`define CSC_OFF_CTRL 12'h000
`define CSC_OFF_ADDR 12'h004
`define CSC_OFF_COMM 12'h008
`define CSC_OFF_STATUS 12'h00c
`define CSC_OFF_ACTIVE 12'h010
`define CSC_OFF_STORED 12'h014
`define CSC_OFF_CHAN 12'h018

`define CSC_COMM_BAUD_LSB 8
`define CSC_COMM_CKSUM_BIT 11
`define CSC_COMM_PROTO_BIT 12
`define CSC_ST_CFG_BIT 0
`define CSC_ST_REFUSED_BIT 1
`define CSC_ST_READY_BIT 2
`define CSC_ST_OVERDUE_BIT 3

`define CSC_FACTORY_ADDR 8'h01
`define CSC_FALLBACK_ADDR 8'h00
`define CSC_BAUD_300 3'h0
`define CSC_BAUD_9600 3'h5
`define CSC_BAUD_38400 3'h7

`define CSC_CLK_HZ 40000000
`define CSC_REPLY_MS 100
`define CSC_FRAME_BITS 10
`define CSC_BOOT_WAIT 2'h3

`endif

// ### shared/csc_pkg.sv
// Types shared by the communication setup block.
// Assumes nothing beyond a SystemVerilog compiler.
package csc_pkg;

  typedef enum logic [2:0] {
    CSC_BOOT = 3'b001,
    CSC_CFG = 3'b010,
    CSC_RUN = 3'b100
  } csc_state_t;

  typedef struct packed {
    logic modbus;
    logic cksum;
    logic [2:0] baud;
    logic [7:0] addr;
  } csc_comm_t;

endpackage

// ### shared/csc_baud_if.sv
// Carrier between the setup block and its bit-rate generator.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface csc_baud_if;
  logic [2:0] baud_code;
  logic run;
  logic bit_tick;
  logic char_tick;
  modport ctrl (output baud_code, output run, input bit_tick,
    input char_tick);
  modport gen (input baud_code, input run, output bit_tick,
    output char_tick);
endinterface
`default_nettype wire

// ### verilog/csc_baud_gen.sv
// Bit-rate generator: one-cycle enables per bit and per character.
// Assumes pclk at the rate given in the configuration header.
`timescale 1ns/1ps
`default_nettype none
`include "csc_cfg.svh"
module csc_baud_gen (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Rate selection and ticks.
  csc_baud_if.gen bi
);
  import csc_pkg::*;

  function automatic logic [17:0] csc_div(input logic [2:0] code);
    logic [31:0] r;
    r = 32'(`CSC_CLK_HZ / (300 << code));
    if (code == `CSC_BAUD_38400)
      r = 32'(`CSC_CLK_HZ / 38400);
    return r[17:0] - 18'h1;
  endfunction

  logic [17:0] div_reg;
  logic [3:0] bit_reg;
  logic bit_tick_reg, char_tick_reg;
  wire div_end = (div_reg >= csc_div(bi.baud_code));
  wire char_end = (bit_reg == 4'(`CSC_FRAME_BITS - 1));

  // Eight rates, each a doubling of the one below, from 300 up to 38400.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_reg <= 18'h0;
      bit_reg <= 4'h0;
      bit_tick_reg <= 1'b0;
      char_tick_reg <= 1'b0;
    end
    else
    begin
      bit_tick_reg <= bi.run && div_end;
      char_tick_reg <= bi.run && div_end && char_end;
      if (!bi.run || div_end)
        div_reg <= 18'h0;
      else
        div_reg <= div_reg + 18'h1;
      if (!bi.run)
        bit_reg <= 4'h0;
      else if (div_end)
        bit_reg <= char_end ? 4'h0 : bit_reg + 4'h1;
    end
  end

  assign bi.bit_tick = bit_tick_reg;
  assign bi.char_tick = char_tick_reg;
endmodule // csc_baud_gen
`default_nettype wire

// ### verilog/csc_comm_setup.sv
// Start-up communication settings with strap-selected fallback, on APB.
// Assumes the strap pin is asynchronous and the APB master is on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "csc_cfg.svh"
module csc_comm_setup #(
  parameter int NUM_CH = 4,
  parameter int REPLY_CYCLES = `CSC_CLK_HZ / 1000 * `CSC_REPLY_MS
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Setup strap pin, low when tied to ground.
  input wire logic config_strap_n,
  // Command handshake with the serial front end.
  input wire logic cmd_received,
  input wire logic reply_started,
  // Settings in force.
  output logic [7:0] node_addr,
  output logic [2:0] baud_code,
  output logic cksum_en,
  output logic proto_modbus,
  output logic config_mode,
  output logic settings_ready,
  output logic [3:0] chan_en,
  output logic reply_overdue,
  // Line timing.
  output logic bit_tick,
  output logic char_tick
);
  import csc_pkg::*;

  localparam int RW = $clog2(REPLY_CYCLES + 1);
  localparam logic [3:0] CH_MASK = (NUM_CH == 2) ? 4'h3 : 4'hf;
  localparam csc_comm_t FACTORY = '{modbus: 1'b0, cksum: 1'b0,
    baud: `CSC_BAUD_9600, addr: `CSC_FACTORY_ADDR};
  localparam csc_comm_t FALLBACK = '{modbus: 1'b0, cksum: 1'b0,
    baud: `CSC_BAUD_9600, addr: `CSC_FALLBACK_ADDR};

  csc_baud_if bi ();
  csc_baud_gen u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .bi(bi)
  );

  logic strap_meta_reg, strap_sync_reg;
  csc_state_t state_reg, state_next;
  logic [1:0] boot_cnt_reg;
  csc_comm_t stored_reg, active_reg;
  logic [3:0] chan_reg;
  logic refused_reg, overdue_reg, waiting_reg;
  logic [RW-1:0] reply_cnt_reg;
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;

  // Bus decode.
  wire acc = psel && penable && pready_reg;
  wire wr = acc && pwrite;
  wire hit_ctrl = (paddr == `CSC_OFF_CTRL);
  wire hit_addr = (paddr == `CSC_OFF_ADDR);
  wire hit_comm = (paddr == `CSC_OFF_COMM);
  wire hit_stat = (paddr == `CSC_OFF_STATUS);
  wire hit_act = (paddr == `CSC_OFF_ACTIVE);
  wire hit_sto = (paddr == `CSC_OFF_STORED);
  wire hit_chan = (paddr == `CSC_OFF_CHAN);
  wire hit_any = hit_ctrl || hit_addr || hit_comm || hit_stat || hit_act
    || hit_sto || hit_chan;
  wire in_cfg = (state_reg == CSC_CFG);
  wire comm_refuse = hit_comm && !in_cfg;
  wire wr_restart = wr && hit_ctrl && pwdata[0];
  wire wr_addr = wr && hit_addr;
  wire wr_comm = wr && hit_comm && in_cfg;
  wire wr_chan = wr && hit_chan;
  wire refuse_evt = wr && comm_refuse;
  wire access_wait = psel && penable && !pready_reg;
  wire bad_access = !hit_any || (pwrite && comm_refuse);
  wire clr_refused = wr && hit_stat && pwdata[`CSC_ST_REFUSED_BIT];
  wire clr_overdue = wr && hit_stat && pwdata[`CSC_ST_OVERDUE_BIT];
  wire boot_done = (state_reg == CSC_BOOT)
    && (boot_cnt_reg == `CSC_BOOT_WAIT);
  wire reply_late = waiting_reg && !reply_started
    && (reply_cnt_reg == RW'(REPLY_CYCLES - 1));

  // Packs a settings record into its register word.
  function automatic logic [31:0] comm_word(input csc_comm_t s);
    return {19'h0, s.modbus, s.cksum, s.baud, s.addr};
  endfunction

  wire [31:0] comm_word_act = comm_word(active_reg);
  wire [31:0] comm_word_sto = comm_word(stored_reg);
  wire [31:0] stat_word = {28'h0, overdue_reg, (state_reg != CSC_BOOT),
    refused_reg, in_cfg};
  wire [31:0] rd_mux = hit_act ? comm_word_act :
    hit_sto ? comm_word_sto :
    hit_stat ? stat_word :
    hit_chan ? {28'h0, chan_reg} :
    hit_addr ? {24'h0, stored_reg.addr} : 32'h0;

  // Strap pin synchroniser.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_meta_reg <= 1'b1;
      strap_sync_reg <= 1'b1;
    end
    else
    begin
      strap_meta_reg <= config_strap_n;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // Start-up sequence: wait for the strap, then pick the settings.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      CSC_BOOT:
        if (boot_done)
          state_next = strap_sync_reg ? CSC_RUN : CSC_CFG;
      CSC_CFG:
        if (wr_restart)
          state_next = CSC_BOOT;
      CSC_RUN:
        if (wr_restart)
          state_next = CSC_BOOT;
      default:
        state_next = CSC_BOOT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= CSC_BOOT;
      boot_cnt_reg <= 2'h0;
      active_reg <= FALLBACK;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg != CSC_BOOT)
        boot_cnt_reg <= 2'h0;
      else if (!boot_done)
        boot_cnt_reg <= boot_cnt_reg + 2'h1;
      if (boot_done)
        active_reg <= strap_sync_reg ? stored_reg : FALLBACK;
    end
  end

  // Kept settings, written by configuration commands.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stored_reg <= FACTORY;
    else
    begin
      if (wr_addr)
        stored_reg.addr <= pwdata[7:0];
      if (wr_comm)
      begin
        stored_reg.baud <= pwdata[`CSC_COMM_BAUD_LSB +: 3];
        stored_reg.cksum <= pwdata[`CSC_COMM_CKSUM_BIT];
        stored_reg.modbus <= pwdata[`CSC_COMM_PROTO_BIT];
      end
    end
  end

  // Channel enables; the upper two stay off when NUM_CH is 2, none otherwise.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chan_reg <= CH_MASK;
    else if (wr_chan)
      chan_reg <= pwdata[3:0] & CH_MASK;
  end

  // Reply deadline watch.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      waiting_reg <= 1'b0;
      reply_cnt_reg <= '0;
    end
    else
    begin
      if (reply_started || reply_late)
        waiting_reg <= 1'b0;
      else if (cmd_received)
        waiting_reg <= 1'b1;
      if (!waiting_reg || cmd_received)
        reply_cnt_reg <= '0;
      else
        reply_cnt_reg <= reply_cnt_reg + RW'(1);
    end
  end

  // Sticky status flags; a set in the same cycle beats a clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      overdue_reg <= 1'b0;
      refused_reg <= 1'b0;
    end
    else
    begin
      if (reply_late)
        overdue_reg <= 1'b1;
      else if (clr_overdue)
        overdue_reg <= 1'b0;
      if (refuse_evt)
        refused_reg <= 1'b1;
      else if (clr_refused)
        refused_reg <= 1'b0;
    end
  end

  // Bus answer one cycle into the access phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end
    else
    begin
      pready_reg <= access_wait;
      pslverr_reg <= access_wait && bad_access;
      if (access_wait && !pwrite)
        prdata_reg <= rd_mux;
      else
        prdata_reg <= 32'h0;
    end
  end

  assign bi.baud_code = active_reg.baud;
  assign bi.run = (state_reg != CSC_BOOT);

  // Output stage.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      node_addr <= 8'h0;
      baud_code <= 3'h0;
      cksum_en <= 1'b0;
      proto_modbus <= 1'b0;
      config_mode <= 1'b0;
      settings_ready <= 1'b0;
      chan_en <= 4'h0;
      reply_overdue <= 1'b0;
      bit_tick <= 1'b0;
      char_tick <= 1'b0;
    end
    else
    begin
      node_addr <= active_reg.addr;
      baud_code <= active_reg.baud;
      cksum_en <= active_reg.cksum;
      proto_modbus <= active_reg.modbus;
      config_mode <= in_cfg;
      settings_ready <= (state_reg != CSC_BOOT);
      chan_en <= chan_reg;
      reply_overdue <= overdue_reg;
      // A tick still in the generator at a restart is not passed on.
      bit_tick <= bi.bit_tick && bi.run;
      char_tick <= bi.char_tick && bi.run;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
endmodule // csc_comm_setup
`default_nettype wire

// ### bench/csc_comm_setup_properties.sv
// Port checks for the communication setup block.
// Bound to the top module from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module csc_comm_setup_properties #(
  parameter int REPLY_CYCLES = 50
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Reply handshake and settings.
  input wire logic cmd_received,
  input wire logic reply_started,
  input wire logic [7:0] node_addr,
  input wire logic [2:0] baud_code,
  input wire logic cksum_en,
  input wire logic proto_modbus,
  input wire logic config_mode,
  input wire logic settings_ready,
  input wire logic reply_overdue,
  input wire logic bit_tick
);
  int wait_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  // Counts edges since a command while no reply has begun.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wait_cnt <= 0;
    else if (cmd_received)
      wait_cnt <= 1;
    else if (reply_started)
      wait_cnt <= 0;
    else if (wait_cnt != 0)
      wait_cnt <= wait_cnt + 1;
  end
  a_pready_wait:
    assert property (s_access |=> pready) else $error("ready late");
  a_pready_pulse:
    assert property (pready |=> !pready) else $error("ready held");
  a_idle_rdata:
    assert property (!pready |-> prdata == 32'h0) else $error("rdata idle");
  a_comm_refused:
    assert property (s_done ##0 (pwrite && paddr == 12'h008 && !config_mode)
      |-> pslverr) else $error("comm not refused");
  a_unmapped_err:
    assert property (s_done ##0 (paddr > 12'h018) |-> pslverr)
      else $error("unmapped ok");
  a_cfg_fixed:
    assert property (config_mode && settings_ready |-> node_addr == 8'h00
      && baud_code == 3'h5 && !cksum_en && !proto_modbus)
      else $error("fallback wrong");
  a_reply_late:
    assert property (wait_cnt == REPLY_CYCLES + 4 |-> reply_overdue)
      else $error("overdue missing");
  a_tick_ready:
    assert property (bit_tick |-> settings_ready) else $error("early tick");
endmodule // csc_comm_setup_properties
`default_nettype wire

// ### bench/csc_front_model.sv
// Serial front end model: command pulses and prompt or slow replies.
// Assumes the bench clock and reset of the setup block.
`timescale 1ns/1ps
`default_nettype none
module csc_front_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bench controls.
  input wire logic go,
  input wire logic slow,
  // Command handshake.
  output logic cmd_received,
  output logic reply_started
);
  int cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 0;
      cmd_received <= 1'b0;
      reply_started <= 1'b0;
    end
    else
    begin
      cmd_received <= go;
      reply_started <= (cnt == 1);
      if (go)
        cnt <= slow ? 200 : 3;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule // csc_front_model
`default_nettype wire

// ### bench/csc_comm_setup_tb_top.sv
// Self-checking bench for the communication setup block.
// Drives APB and the strap; a front end model makes commands.
`timescale 1ns/1ps
`default_nettype none
module csc_comm_setup_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic strap_n, cmd_received, reply_started, go, slow, cksum_en;
  logic proto_modbus, config_mode, settings_ready, reply_overdue;
  logic bit_tick, char_tick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] node_addr, a;
  logic [2:0] baud_code;
  logic [3:0] chan_en, chan_en2, c;
  logic [1:0] m;
  int err_count, total_checks, n, b;
  csc_comm_setup #(.NUM_CH(4), .REPLY_CYCLES(50)) i_csc_comm_setup (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .config_strap_n(strap_n),
    .cmd_received(cmd_received), .reply_started(reply_started),
    .node_addr(node_addr), .baud_code(baud_code), .cksum_en(cksum_en),
    .proto_modbus(proto_modbus), .config_mode(config_mode),
    .settings_ready(settings_ready), .chan_en(chan_en),
    .reply_overdue(reply_overdue), .bit_tick(bit_tick),
    .char_tick(char_tick));
  csc_comm_setup #(.NUM_CH(2), .REPLY_CYCLES(50)) i_csc_comm_setup_2ch (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .config_strap_n(strap_n),
    .cmd_received(cmd_received), .reply_started(reply_started),
    .node_addr(), .baud_code(), .cksum_en(), .proto_modbus(),
    .config_mode(), .settings_ready(), .chan_en(chan_en2),
    .reply_overdue(), .bit_tick(), .char_tick());
  csc_front_model i_csc_front_model (.pclk(pclk), .presetn(presetn),
    .go(go), .slow(slow), .cmd_received(cmd_received),
    .reply_started(reply_started));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  function automatic logic [31:0] cs(logic [7:0] ad, logic [2:0] bd,
    logic ck, logic mb);
    return {19'h0, mb, ck, bd, ad};
  endfunction
  task summarize;
    begin
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    begin
      total_checks++;
      if (s !== x)
      begin
        err_count++;
        $display("[FAIL] %0t got %h exp %h", $time, s, x);
      end
    end
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int k;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
        @(posedge pclk);
        k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
        err_count++;
        summarize();
      end
    end
  endtask
  task rdy;
    int k;
    begin
      repeat (6) @(posedge pclk);
      for (k = 0; k < 50 && settings_ready !== 1'b1; k++)
        @(posedge pclk);
      chk(settings_ready, 1);
    end
  endtask
  task gap(input logic sel, output int q);
    int k, t;
    begin
      k = 0;
      q = 0;
      for (t = 0; k < 2 && t < 20000; t++)
      begin
        @(posedge pclk);
        q += k;
        if ((sel ? char_tick : bit_tick) === 1'b1)
          k++;
      end
      if (k < 2)
        q = -1;
    end
  endtask
  task fire;
    begin
      @(posedge pclk);
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      repeat (80) @(posedge pclk);
    end
  endtask
  initial
  begin
    void'($urandom(57));
    {psel, penable, pwrite, go, slow, paddr, pwdata} = '0;
    presetn = 1'b0;
    strap_n = 1'b1;
    err_count = 0;
    total_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdy();
    apb(0, 12'h010, 32'h0);
    chk(rd, cs(8'h01, 3'h5, 1'b0, 1'b0));
    chk(config_mode, 0);
    chk(chan_en2, 32'h3);
    apb(1, 12'h008, cs(8'h00, 3'h7, 1'b1, 1'b1));
    chk(er, 1);
    apb(0, 12'h00c, 32'h0);
    chk(rd[1], 1);
    a = 8'($urandom);
    apb(1, 12'h004, 32'hff);
    apb(0, 12'h004, 32'h0);
    chk(rd[7:0], 8'hff);
    apb(1, 12'h004, {24'h0, a});
    apb(0, 12'h014, 32'h0);
    chk(rd, cs(a, 3'h5, 1'b0, 1'b0));
    c = 4'($urandom);
    apb(1, 12'h018, {28'h0, c});
    apb(0, 12'h018, 32'h0);
    chk(rd, {28'h0, c});
    chk(chan_en, {28'h0, c});
    chk(chan_en2, {28'h0, c & 4'h3});
    apb(0, 12'h01c, 32'h0);
    chk(er, 32'h1);
    chk(rd, 32'h0);
    strap_n <= 1'b0;
    apb(1, 12'h000, 32'h1);
    rdy();
    chk(config_mode, 1);
    chk(node_addr, 32'h0);
    apb(0, 12'h010, 32'h0);
    chk(rd, cs(8'h00, 3'h5, 1'b0, 1'b0));
    for (b = 0; b < 8; b++)
    begin
      m = 2'($urandom);
      apb(1, 12'h008, cs(8'h00, b[2:0], m[0], m[1]));
      chk(er, 0);
      apb(0, 12'h014, 32'h0);
      chk(rd, cs(a, b[2:0], m[0], m[1]));
    end
    apb(1, 12'h008, cs(8'h00, 3'h7, 1'b1, 1'b1));
    strap_n <= 1'b1;
    apb(1, 12'h000, 32'h1);
    rdy();
    apb(0, 12'h010, 32'h0);
    chk(rd, cs(a, 3'h7, 1'b1, 1'b1));
    chk(proto_modbus, 1);
    chk(node_addr, {24'h0, a});
    chk(baud_code, 32'h7);
    chk(cksum_en, 32'h1);
    gap(0, n);
    chk(n, 40000000 / 38400);
    gap(1, n);
    chk(n, 10 * (40000000 / 38400));
    fire();
    chk(reply_overdue, 0);
    slow <= 1'b1;
    fire();
    chk(reply_overdue, 1);
    apb(1, 12'h00c, 32'h8);
    repeat (2) @(posedge pclk);
    chk(reply_overdue, 0);
    summarize();
  end
endmodule // csc_comm_setup_tb_top
bind csc_comm_setup csc_comm_setup_properties #(
  .REPLY_CYCLES(REPLY_CYCLES)) i_csc_comm_setup_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cmd_received(cmd_received),
  .reply_started(reply_started), .node_addr(node_addr),
  .baud_code(baud_code), .cksum_en(cksum_en),
  .proto_modbus(proto_modbus), .config_mode(config_mode),
  .settings_ready(settings_ready), .reply_overdue(reply_overdue),
  .bit_tick(bit_tick));
`default_nettype wire
